// File: logic/rsc_cpu_div.sv
/*
 * rsc_cpu_div: instruction clock enable, one pulse every 1, 2, 4 or 8 oscillator clocks.
 * Assumes run_in is low whenever the system reset is active.
 */
`timescale 1ns/1ps
module rsc_cpu_div
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // control
   input wire logic run_in,
   input wire logic [1:0] div_sel_in,
   // instruction cycle tick
   output logic tick_out
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   logic [2:0] last;

   always_comb begin
      last = 3'((4'h1 << div_sel_in) - 4'h1);
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (run_in) begin
         if (cnt_reg >= last) begin
            cnt_next = 3'h0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 3'h1;
         end
      end else begin
         cnt_next = 3'h0;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg <= 3'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_out = tick_reg;
endmodule // rsc_cpu_div

// File: logic/rsc_pkg.sv
/*
 * rsc_pkg: constants and carriers for the reset source and configuration block.
 * Assumes a 200 MHz core clock and a 32-bit APB register bus.
 */
package rsc_pkg;
   // flag register is kept by word index; its byte address is four times the index
   localparam logic [7:0] RSC_FLAG_IDX = 8'h86;
   localparam logic [11:0] RSC_FLAG_ADDR = {2'h0, RSC_FLAG_IDX, 2'h0};
   localparam logic [11:0] RSC_CFG_ADDR = 12'h000;
   localparam logic [11:0] RSC_CTL_ADDR = 12'h004;
   localparam logic [11:0] RSC_STAT_ADDR = 12'h008;
   // field positions
   localparam int RSC_TIMEOUT_FLAG_POS = 7;
   localparam int RSC_PWRDN_FLAG_POS = 6;
   // cause codes {timeout_flag_n, powerdown_flag_n}
   localparam logic [1:0] RSC_CAUSE_WDT = 2'h0;
   localparam logic [1:0] RSC_CAUSE_POR = 2'h2;
   localparam logic [1:0] RSC_CAUSE_EXT = 2'h3;
   // timing
   localparam int RSC_CLK_MHZ = 200;
   localparam int RSC_PWR_STABLE_NS = 1000;
   localparam int RSC_PWR_STABLE_CYC = (RSC_PWR_STABLE_NS * RSC_CLK_MHZ + 999) / 1000;
   localparam int RSC_WARM_RC_CYC = 64;
   localparam int RSC_WARM_XTAL_CYC = 4096;
   localparam int RSC_CNT_W = 13;
   // reset values
   localparam logic [7:0] RSC_CFG_RST = 8'h00;

   typedef enum logic [2:0] {
      RSC_HCLK_INT_RC, RSC_HCLK_RC, RSC_HCLK_LOWX, RSC_HCLK_4MX, RSC_HCLK_8MX
   } rsc_hclk_e;
   typedef enum logic [1:0] {RSC_WDT_OFF, RSC_WDT_ON, RSC_WDT_ALWAYS} rsc_wdt_e;

   // configuration option set, packed into an 8-bit word
   typedef struct packed {
      logic security;
      logic pin_is_reset;
      rsc_wdt_e wdt;
      logic [1:0] cpu_div;
      logic [0:0] rsvd;
      logic spare;
   } rsc_cfg_hi_s;

   typedef struct packed {
      rsc_hclk_e hclk;
      logic [1:0] cpu_div;
      rsc_wdt_e wdt;
      logic pin_is_reset;
      logic security;
   } rsc_cfg_s;

   // options before the storage word is taken: secured, so no dump slips out early
   localparam rsc_cfg_s RSC_CFG_RST_S = '{hclk: RSC_HCLK_INT_RC, cpu_div: 2'h0,
      wdt: RSC_WDT_OFF, pin_is_reset: 1'b0, security: 1'b1};

   // events from the supply and watchdog side
   typedef struct packed {
      logic supply_ok;
      logic undervoltage;
      logic wdt_overflow;
   } rsc_src_s;
endpackage

// File: logic/rsc_top.sv
/*
 * rsc_top: reset sources, power-on sequencing, option decode and reset cause flags.
 * Assumes option word from non-volatile storage is stable at nvm_valid_in, pins
 * arrive asynchronously, APB master on the core clock.
 */
`timescale 1ns/1ps
module rsc_top
   import rsc_pkg::*;
#(
   parameter int WARM_XTAL_CYC = RSC_WARM_XTAL_CYC
)(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // option storage
   input wire logic [7:0] nvm_opt_in,
   input wire logic nvm_valid_in,
   // reset sources
   input wire logic supply_ok_in,
   input wire logic undervoltage_in,
   input wire logic wdt_overflow_in,
   input wire logic shared_input_pin_in,
   input wire logic powerdown_in,
   input wire logic green_in,
   input wire logic rom_dump_req_in,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system outputs
   output logic sys_rst_n_out,
   output logic pc_clear_out,
   output logic cpu_tick_out,
   output logic wdt_run_out,
   output logic int_osc_en_out,
   output logic osc_in_pin_gpio_out,
   output logic osc_out_pin_gpio_out,
   output logic shared_pin_pullup_out,
   output logic rom_dump_allow_out
);
   typedef enum {ST_LOAD, ST_PWR, ST_PIN, ST_INIT, ST_WARM, ST_RUN} rsc_state_e;

   rsc_state_e st_reg, st_next;
   rsc_cfg_s cfg_reg, cfg_next;
   logic [RSC_CNT_W-1:0] cnt_reg, cnt_next;
   logic [1:0] cause_reg, cause_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [2:0] pin_sync_reg, pin_sync_next;
   logic [1:0] sup_sync_reg, sup_sync_next, uv_sync_reg, uv_sync_next;
   logic [1:0] wdt_sync_reg, wdt_sync_next;
   logic rst_n_reg, rst_n_next, pcclr_reg, pcclr_next;
   logic wdt_run_reg, wdt_run_next, iosc_reg, iosc_next;
   logic gin_reg, gin_next, gout_reg, gout_next, pu_reg, pu_next, dump_reg, dump_next;
   logic pin_fall, wdt_evt, any_reset, rc_type, warm_done;
   logic [RSC_CNT_W-1:0] warm_last;
   logic acc_ok;

   // pin, supply, undervoltage and watchdog synchronisers, stage 0 read only by stage 1
   always_comb begin
      pin_sync_next = {pin_sync_reg[1:0], shared_input_pin_in};
      sup_sync_next = {sup_sync_reg[0], supply_ok_in};
      uv_sync_next = {uv_sync_reg[0], undervoltage_in};
      wdt_sync_next = {wdt_sync_reg[0], wdt_overflow_in};
   end

   always_comb begin
      pin_fall = cfg_reg.pin_is_reset && pin_sync_reg[2] && !pin_sync_reg[1];
      wdt_evt = wdt_sync_reg[1] && (cfg_reg.wdt != RSC_WDT_OFF);
      any_reset = wdt_evt || pin_fall || uv_sync_reg[1] || !sup_sync_reg[1];
      rc_type = (cfg_reg.hclk == RSC_HCLK_INT_RC) || (cfg_reg.hclk == RSC_HCLK_RC);
      warm_last = rc_type ? RSC_CNT_W'(RSC_WARM_RC_CYC - 1) : RSC_CNT_W'(WARM_XTAL_CYC - 1);
      warm_done = (cnt_reg == warm_last);
   end

   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      cfg_next = cfg_reg;
      cause_next = cause_reg;
      unique case (st_reg)
         ST_LOAD: begin
            if (nvm_valid_in) begin
               cfg_next.hclk = rsc_hclk_e'(nvm_opt_in[2:0] > 3'h4 ? 3'h0 : nvm_opt_in[2:0]);
               cfg_next.cpu_div = nvm_opt_in[4:3];
               cfg_next.wdt = rsc_wdt_e'(nvm_opt_in[6:5] == 2'h3 ? 2'h2 : nvm_opt_in[6:5]);
               cfg_next.pin_is_reset = !nvm_opt_in[7];
               cfg_next.security = 1'b1;
               st_next = ST_PWR;
               cnt_next = '0;
            end
         end
         ST_PWR: begin
            if (!sup_sync_reg[1] || uv_sync_reg[1]) begin
               cnt_next = '0;
            end else if (cnt_reg == RSC_CNT_W'(RSC_PWR_STABLE_CYC - 1)) begin
               st_next = ST_PIN;
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_PIN: begin
            if (!cfg_reg.pin_is_reset || pin_sync_reg[2]) begin
               st_next = ST_INIT;
            end
         end
         ST_INIT: begin
            st_next = ST_WARM;
            cnt_next = '0;
         end
         ST_WARM: begin
            if (warm_done) begin
               st_next = ST_RUN;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_RUN: begin
            if (any_reset) begin
               st_next = (wdt_evt || pin_fall) ? ST_INIT : ST_PWR;
               cnt_next = '0;
            end
         end
      endcase
      if (st_reg != ST_LOAD && st_reg != ST_PWR && (uv_sync_reg[1] || !sup_sync_reg[1])) begin
         st_next = ST_PWR;
         cnt_next = '0;
      end
      if (st_reg != ST_LOAD && (uv_sync_reg[1] || !sup_sync_reg[1])) begin
         cause_next = RSC_CAUSE_POR;
      end else if (st_reg == ST_RUN && wdt_evt) begin
         cause_next = RSC_CAUSE_WDT;
      end else if (st_reg == ST_RUN && pin_fall) begin
         cause_next = RSC_CAUSE_EXT;
      end else if (psel && penable && pwrite && paddr == RSC_FLAG_ADDR) begin
         cause_next = pwdata[RSC_TIMEOUT_FLAG_POS:RSC_PWRDN_FLAG_POS];
      end
   end

   // outputs and apb
   always_comb begin
      rst_n_next = (st_next == ST_RUN);
      pcclr_next = (st_next != ST_RUN);
      wdt_run_next = (cfg_reg.wdt == RSC_WDT_ALWAYS) ||
                     ((cfg_reg.wdt == RSC_WDT_ON) && !powerdown_in && !green_in);
      iosc_next = (cfg_reg.hclk == RSC_HCLK_INT_RC);
      gin_next = (cfg_reg.hclk == RSC_HCLK_INT_RC);
      gout_next = rc_type;
      pu_next = cfg_reg.pin_is_reset;
      dump_next = rom_dump_req_in && !cfg_reg.security;
      acc_ok = (paddr == RSC_FLAG_ADDR) || (paddr == RSC_CFG_ADDR) ||
               (paddr == RSC_STAT_ADDR);
      pready_next = psel && !penable;
      pslverr_next = psel && !penable && !acc_ok;
      prdata_next = prdata_reg;
      if (psel && !penable && !pwrite) begin
         prdata_next = 32'h0;
         if (paddr == RSC_FLAG_ADDR) begin
            prdata_next[RSC_TIMEOUT_FLAG_POS:RSC_PWRDN_FLAG_POS] = cause_reg;
         end else if (paddr == RSC_CFG_ADDR) begin
            prdata_next[7:0] = {!cfg_reg.pin_is_reset, cfg_reg.wdt, cfg_reg.cpu_div, cfg_reg.hclk};
            prdata_next[8] = cfg_reg.security;
         end else if (paddr == RSC_STAT_ADDR) begin
            prdata_next[2:0] = 3'(st_reg);
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= ST_LOAD;
         cnt_reg <= '0;
         cfg_reg <= RSC_CFG_RST_S;
         cause_reg <= RSC_CAUSE_POR;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         pin_sync_reg <= 3'h7;
         sup_sync_reg <= 2'h0;
         uv_sync_reg <= 2'h0;
         wdt_sync_reg <= 2'h0;
         rst_n_reg <= 1'b0;
         pcclr_reg <= 1'b1;
         wdt_run_reg <= 1'b0;
         iosc_reg <= 1'b0;
         gin_reg <= 1'b0;
         gout_reg <= 1'b0;
         pu_reg <= 1'b0;
         dump_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         cfg_reg <= cfg_next;
         cause_reg <= cause_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         pin_sync_reg <= pin_sync_next;
         sup_sync_reg <= sup_sync_next;
         uv_sync_reg <= uv_sync_next;
         wdt_sync_reg <= wdt_sync_next;
         rst_n_reg <= rst_n_next;
         pcclr_reg <= pcclr_next;
         wdt_run_reg <= wdt_run_next;
         iosc_reg <= iosc_next;
         gin_reg <= gin_next;
         gout_reg <= gout_next;
         pu_reg <= pu_next;
         dump_reg <= dump_next;
      end
   end

   rsc_cpu_div u_div (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .run_in(st_reg == ST_RUN),
      .div_sel_in(cfg_reg.cpu_div),
      .tick_out(cpu_tick_out)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sys_rst_n_out = rst_n_reg;
   assign pc_clear_out = pcclr_reg;
   assign wdt_run_out = wdt_run_reg;
   assign int_osc_en_out = iosc_reg;
   assign osc_in_pin_gpio_out = gin_reg;
   assign osc_out_pin_gpio_out = gout_reg;
   assign shared_pin_pullup_out = pu_reg;
   assign rom_dump_allow_out = dump_reg;

   property p_wdt_off;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (cfg_reg.wdt == RSC_WDT_OFF && st_reg == ST_RUN) |=> st_reg == ST_RUN
         || $past(!sup_sync_reg[1] || uv_sync_reg[1] || pin_fall);
   endproperty
   a_wdt_off: assert property (p_wdt_off) else $error("watchdog reset while disabled");
   property p_hold;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (st_reg != ST_RUN) |-> !sys_rst_n_out && pc_clear_out;
   endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_pin;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (st_reg == ST_PIN && cfg_reg.pin_is_reset && !pin_sync_reg[2])
         |=> st_reg == ST_PIN || st_reg == ST_PWR;
   endproperty
   a_pin: assert property (p_pin) else $error("left pin wait with pin low");
   property p_warm;
      @(posedge core_clk_in) disable iff (!nrst_in)
      $rose(st_reg == ST_RUN) |-> $past(st_reg) == ST_WARM;
   endproperty
   a_warm: assert property (p_warm) else $error("run without warm-up");
   property p_sec;
      @(posedge core_clk_in) disable iff (!nrst_in)
      cfg_reg.security |=> !rom_dump_allow_out;
   endproperty
   a_sec: assert property (p_sec) else $error("dump allowed while secured");
   property p_uv;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (uv_sync_reg[1] && st_reg == ST_RUN) |=> st_reg == ST_PWR ##1 !sys_rst_n_out;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage did not reset");
   property p_cause;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (st_reg == ST_RUN && wdt_evt && sup_sync_reg[1] && !uv_sync_reg[1])
         |=> cause_reg == RSC_CAUSE_WDT;
   endproperty
   a_cause: assert property (p_cause) else $error("watchdog cause not recorded");
   property p_pu;
      @(posedge core_clk_in) disable iff (!nrst_in)
      !cfg_reg.pin_is_reset |=> !shared_pin_pullup_out;
   endproperty
   a_pu: assert property (p_pu) else $error("pull-up on input pin");
   c_run: cover property (@(posedge core_clk_in) $rose(st_reg == ST_RUN));
   c_wdt: cover property (@(posedge core_clk_in) st_reg == ST_RUN && wdt_evt);
   c_pin: cover property (@(posedge core_clk_in) st_reg == ST_RUN && pin_fall);
endmodule // rsc_top

// File: test/rsc_far_side.sv
/*
 * rsc_far_side: supply monitor and external reset circuit that face rsc_top.
 * Assumes the bench commands supply loss and pin pull-down; lines are levels.
 */
`timescale 1ns/1ps
module rsc_far_side #(
   parameter int RAMP_CYC = 20
)(
   // clock
   input wire logic core_clk_in,
   // bench commands
   input wire logic power_good_in,
   input wire logic pin_low_in,
   // lines into the device
   output logic supply_ok_out,
   output logic undervoltage_out,
   output logic shared_pin_out
);
   int ramp = 0;

   // supply takes a while to climb, so supply_ok lags power_good
   always @(posedge core_clk_in) begin
      if (!power_good_in)
         ramp <= 0;
      else if (ramp < RAMP_CYC)
         ramp <= ramp + 1;
   end

   assign supply_ok_out = (ramp == RAMP_CYC);
   assign undervoltage_out = !power_good_in;
   assign shared_pin_out = !pin_low_in;
endmodule // rsc_far_side

// File: test/test_reset_source_and_config_options.sv
/*
 * test_reset_source_and_config_options: self-checking bench for rsc_top.
 * Assumes rsc_pkg, rsc_cpu_div, rsc_top and rsc_far_side are compiled first.
 */
`timescale 1ns/1ps
module test_reset_source_and_config_options;
   import rsc_pkg::*;
   // crystal warm-up kept above the rc count so the ordering still shows
   localparam int XTAL = 128;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] nvm_opt_in = 8'h00;
   logic nvm_valid_in = 1'b0;
   logic wdt_overflow_in = 1'b0;
   logic powerdown_in = 1'b0;
   logic green_in = 1'b0;
   logic rom_dump_req_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic power_good = 1'b0;
   logic pin_low = 1'b0;
   logic supply_ok, undervoltage, shared_pin, pready, pslverr;
   logic [31:0] prdata;
   logic sys_rst_n_out, pc_clear_out, cpu_tick_out, wdt_run_out, int_osc_en_out;
   logic osc_in_pin_gpio_out, osc_out_pin_gpio_out, shared_pin_pullup_out;
   logic rom_dump_allow_out;
   int failures = 0;
   int n_compared = 0;

   always #2.5 core_clk_in = ~core_clk_in;

   rsc_far_side u_rsc_far_side (.core_clk_in(core_clk_in), .power_good_in(power_good),
      .pin_low_in(pin_low), .supply_ok_out(supply_ok), .undervoltage_out(undervoltage),
      .shared_pin_out(shared_pin));

   rsc_top #(.WARM_XTAL_CYC(XTAL)) u_rsc_top (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .nvm_opt_in(nvm_opt_in), .nvm_valid_in(nvm_valid_in), .supply_ok_in(supply_ok),
      .undervoltage_in(undervoltage), .wdt_overflow_in(wdt_overflow_in),
      .shared_input_pin_in(shared_pin), .powerdown_in(powerdown_in), .green_in(green_in),
      .rom_dump_req_in(rom_dump_req_in), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_rst_n_out(sys_rst_n_out), .pc_clear_out(pc_clear_out),
      .cpu_tick_out(cpu_tick_out), .wdt_run_out(wdt_run_out),
      .int_osc_en_out(int_osc_en_out), .osc_in_pin_gpio_out(osc_in_pin_gpio_out),
      .osc_out_pin_gpio_out(osc_out_pin_gpio_out),
      .shared_pin_pullup_out(shared_pin_pullup_out),
      .rom_dump_allow_out(rom_dump_allow_out));

   function automatic int ticks_in(input int win, input int d);
      return win >> d;
   endfunction

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      failures++;
      $display("BAD %0t %s timed out", $time, what);
      summarize();
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge core_clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (pready !== 1'b1)
         hang("apb");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_rst(input logic v, input int lim, output int n);
      n = 0;
      while (sys_rst_n_out !== v) begin
         @(posedge core_clk_in);
         n++;
         if (n > lim)
            hang("reset wait");
      end
   endtask

   task automatic count_resets(input int win, output int n);
      n = 0;
      repeat (win) begin
         @(posedge core_clk_in);
         if (sys_rst_n_out !== 1'b1)
            n++;
      end
   endtask

   task automatic chk_cause(input logic [1:0] c);
      logic [31:0] rd;
      logic e;
      apb(1'b0, RSC_FLAG_ADDR, 32'h00000000, rd, e);
      chk(32'(rd[7:6]), 32'(c), "cause flags");
   endtask

   task automatic boot(input logic [7:0] opt);
      int n;
      nrst_in <= 1'b0;
      nvm_valid_in <= 1'b0;
      nvm_opt_in <= opt;
      power_good <= 1'b1;
      pin_low <= 1'b0;
      repeat (5) @(posedge core_clk_in);
      chk(32'(pc_clear_out), 32'h1, "pc clear in reset");
      nrst_in <= 1'b1;
      repeat (30) @(posedge core_clk_in);
      // options not yet valid, so the core must still be held
      chk(32'(sys_rst_n_out), 32'h0, "held before options");
      nvm_valid_in <= 1'b1;
      wait_rst(1'b1, 3000, n);
   endtask

   task automatic wdt_hit(output int t);
      int n;
      wdt_overflow_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      wdt_overflow_in <= 1'b0;
      wait_rst(1'b0, 20, n);
      @(posedge core_clk_in);
      chk(32'(pc_clear_out), 32'h1, "pc clear on watchdog");
      wait_rst(1'b1, 3000, t);
   endtask

   initial begin
      int t_rc, t_x, t, n, div;
      logic [31:0] rd, rd2;
      logic e;
      void'($urandom(32'hd911b734));
      t_rc = 0;
      t_x = 0;
      for (int h = 0; h < 5; h++) begin
         div = $urandom_range(3);
         boot({1'b0, 2'h1, div[1:0], h[2:0]});
         chk_cause(RSC_CAUSE_POR);
         chk(32'(pc_clear_out), 32'h0, "pc clear in run");
         chk(32'(int_osc_en_out), 32'(h == 0), "internal osc");
         chk(32'(osc_in_pin_gpio_out), 32'(h == 0), "in pin gpio");
         chk(32'(osc_out_pin_gpio_out), 32'(h < 2), "out pin gpio");
         n = 0;
         repeat (64) begin
            @(posedge core_clk_in);
            if (cpu_tick_out === 1'b1)
               n++;
         end
         chk(n, ticks_in(64, div), "instruction ticks");
         wdt_hit(t);
         chk_cause(RSC_CAUSE_WDT);
         if (h == 1)
            t_rc = t;
         if (h == 3)
            t_x = t;
      end
      chk(t_x - t_rc, XTAL - RSC_WARM_RC_CYC, "warm-up difference");
      // watchdog disabled
      boot(8'h01);
      chk(32'(wdt_run_out), 32'h0, "wdt off run");
      wdt_overflow_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      wdt_overflow_in <= 1'b0;
      count_resets(40, n);
      chk(n, 0, "wdt off no reset");
      for (int m = 1; m < 3; m++) begin
         boot({1'b0, m[1:0], 2'h0, 3'h1});
         chk(32'(wdt_run_out), 32'h1, "wdt normal");
         powerdown_in <= 1'b1;
         repeat (4) @(posedge core_clk_in);
         chk(32'(wdt_run_out), 32'(m == 2), "wdt power-down");
         powerdown_in <= 1'b0;
         green_in <= 1'b1;
         repeat (4) @(posedge core_clk_in);
         chk(32'(wdt_run_out), 32'(m == 2), "wdt green");
         green_in <= 1'b0;
      end
      // reset pin enabled: a short low pulse resets
      boot(8'h21);
      pin_low <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      pin_low <= 1'b0;
      wait_rst(1'b0, 20, n);
      wait_rst(1'b1, 3000, n);
      chk_cause(RSC_CAUSE_EXT);
      // supply loss with pin held low: no release until the pin goes high
      power_good <= 1'b0;
      pin_low <= 1'b1;
      wait_rst(1'b0, 20, n);
      power_good <= 1'b1;
      repeat (400) @(posedge core_clk_in);
      chk(32'(sys_rst_n_out), 32'h0, "held by low pin");
      pin_low <= 1'b0;
      wait_rst(1'b1, 3000, n);
      chk_cause(RSC_CAUSE_POR);
      // pin as general input
      boot(8'ha1);
      chk(32'(shared_pin_pullup_out), 32'h0, "no pull-up");
      pin_low <= 1'b1;
      count_resets(40, n);
      chk(n, 0, "general pin no reset");
      pin_low <= 1'b0;
      // register bus
      apb(1'b0, 12'h100, 32'h00000000, rd, e);
      chk(32'(e), 32'h1, "unmapped error");
      apb(1'b0, RSC_CFG_ADDR, 32'h00000000, rd, e);
      apb(1'b1, RSC_CFG_ADDR, ~rd, rd2, e);
      apb(1'b0, RSC_CFG_ADDR, 32'h00000000, rd2, e);
      chk(rd2, rd, "options fixed");
      apb(1'b1, RSC_FLAG_ADDR, 32'h00000040, rd2, e);
      chk_cause(2'h1);
      rom_dump_req_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      chk(32'(rom_dump_allow_out), 32'h0, "rom dump refused");
      summarize();
   end
endmodule // test_reset_source_and_config_options
